// ### design/hwc_top.sv
// Hardware configuration register with APB slave, soft reset sequencer,
// LED timing, EEPROM wait timer and datapath steering outputs.
// Assumes RSTN is power-on reset and all status inputs are on SYS_CLK,
// except the PHY strap, which is asynchronous.
// Summary of operation
// - No EEPROM: emulation bit picks defaults (0) or descriptor RAM (1)
// - Emulation bit has no effect while an EEPROM is present
// - Protect bit keeps itself and emulation bit through soft resets
// - Empty RX FIFO bulk-in: zero-length packet if 0, NAK if 1
// - Bypass bit shortens LED on/off from 80 ms to 15 us
// - Two-bit receive offset shifts RX data start by 0 to 3 bytes
// - Loss of sync stalls bulk-out unless stall-disable bit is set
// - Internal PHY: visibility bit drives MII pins as outputs
// - Visibility bit ignored with external PHY
// - Visibility overrides GPIO configuration of shared MII pins
// - Discard bit drops errored received frames, else passes them
// - Packing bit allows multiple frames per USB packet
// - EEPROM timeout after 30 ms, or 1.28 us when select bit set
// - Writing 1 to lite bit starts lite reset, core and PHY untouched
// - Lite reset bit clears itself when sequence finishes
// - Read-only bit shows internal (0) or external (1) PHY
// - PHY indication reset value comes from strap pin
// - Burst limit enable selects use of burst size register
// - Full reset bit resets device and external PHY, then self-clears
// - Full soft reset reloads configuration from EEPROM
// - USB PHY disconnected during full reset, reconnected after
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "hwc_params.svh"

module hwc_top #(
	parameter int unsigned LED_NORMAL_CYC = `HWC_LED_NORMAL_MS * 1000 * `HWC_CLK_MHZ,
	parameter int unsigned EE_LONG_CYC = `HWC_EE_LONG_MS * 1000 * `HWC_CLK_MHZ
) (
	// Clock and power-on reset
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [`HWC_ADDR_W-1:0] PADDR,
	input wire hwc_pkg::hwc_word_t PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Device status inputs
	input wire logic PHY_CHOICE_STRAP,
	input wire logic EE_PRESENT,
	input wire logic EE_WAIT,
	input wire logic EE_LOAD_DONE,
	input wire logic RX_FIFO_EMPTY,
	input wire logic BULK_IN_TOKEN,
	input wire logic TX_LOSS_OF_SYNC,
	input wire logic ACT_EVENT,
	// Steering outputs
	output logic DESC_SRC_RAM,
	output logic BULK_IN_NAK,
	output logic BULK_IN_ZLP,
	output logic BULK_OUT_STALL,
	output logic MII_PIN_OE,
	output logic GPIO_MII_OVERRIDE,
	output logic [1:0] RX_BYTE_OFFSET,
	output logic ERR_FRAME_DISCARD,
	output logic MULTI_FRAME_PACK,
	output logic BURST_LIMIT_EN,
	output logic ACT_LED,
	output logic EE_TIMEOUT,
	// Reset sequencer outputs
	output logic LITE_RESET,
	output logic FULL_RESET,
	output logic EXT_PHY_RESET,
	output logic USB_PHY_DISCONNECT,
	output logic EE_RELOAD_REQ
);
	import hwc_pkg::*;

	localparam int AST_LITE_MAX = 40;
	localparam int AST_FULL_MAX = 60;

	logic eem_r, protect_r, bir_r, activity_led_fast_bypass_r, sbp_r, ime_r, drp_r, mef_r, etc_r, bce_r;
	logic [1:0] rxoff_r;
	logic phy_ext_r;
	logic strap_s1_r, strap_s2_r;
	logic [1:0] cap_cnt_r;
	hwc_state_t st_r;
	logic [7:0] seq_cnt_r;
	logic lite_busy, full_busy;
	logic wr_en, addr_hit;
	hwc_word_t rd_word;
	logic soft_clr;

	////////////////////////////////////////////////////////////////////////
	// APB slave: answer in the first access cycle, no wait states

	assign addr_hit = (PADDR[`HWC_ADDR_W-1:2] == (`HWC_ADDR_W-2)'(`HWC_HW_CONFIG_OFS >> 2));
	assign wr_en = PSEL & PENABLE & PREADY & PWRITE & addr_hit;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_word[`HWC_B_EEM] = eem_r;
		rd_word[`HWC_B_PROTECT] = protect_r;
		rd_word[`HWC_B_BIR] = bir_r;
		rd_word[`HWC_B_ACTIVITY_LED_FAST_BYPASS] = activity_led_fast_bypass_r;
		rd_word[`HWC_B_RXOFF_HI:`HWC_B_RXOFF_LO] = rxoff_r;
		rd_word[`HWC_B_SBP] = sbp_r;
		rd_word[`HWC_B_IME] = ime_r;
		rd_word[`HWC_B_DRP] = drp_r;
		rd_word[`HWC_B_MEF] = mef_r;
		rd_word[`HWC_B_ETC] = etc_r;
		rd_word[`HWC_B_LITE_SOFT_RESET] = lite_busy;
		rd_word[`HWC_B_PSEL] = phy_ext_r;
		rd_word[`HWC_B_BCE] = bce_r;
		rd_word[`HWC_B_FULL_SOFT_RESET] = full_busy;
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~addr_hit;
			if (PSEL & ~PENABLE) begin
				PRDATA <= (addr_hit & ~PWRITE) ? rd_word : 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration fields; soft resets clear all but protected ones

	assign soft_clr = (st_r == HWC_ST_LITE || st_r == HWC_ST_FULL) && seq_cnt_r == 8'h00;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			eem_r <= 1'b0;
			protect_r <= 1'b0;
		end else if (wr_en) begin
			eem_r <= PWDATA[`HWC_B_EEM];
			protect_r <= PWDATA[`HWC_B_PROTECT];
		end else if (soft_clr && !protect_r) begin
			eem_r <= 1'b0;
			protect_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			{bir_r, activity_led_fast_bypass_r, rxoff_r, sbp_r, ime_r, drp_r, mef_r, etc_r, bce_r} <= 10'h000;
		end else if (wr_en) begin
			bir_r <= PWDATA[`HWC_B_BIR];
			activity_led_fast_bypass_r <= PWDATA[`HWC_B_ACTIVITY_LED_FAST_BYPASS];
			// Offset is trusted to stay fixed once RX runs
			rxoff_r <= PWDATA[`HWC_B_RXOFF_HI:`HWC_B_RXOFF_LO];
			sbp_r <= PWDATA[`HWC_B_SBP];
			ime_r <= PWDATA[`HWC_B_IME];
			drp_r <= PWDATA[`HWC_B_DRP];
			mef_r <= PWDATA[`HWC_B_MEF];
			etc_r <= PWDATA[`HWC_B_ETC];
			bce_r <= PWDATA[`HWC_B_BCE];
		end else if (soft_clr) begin
			{bir_r, activity_led_fast_bypass_r, rxoff_r, sbp_r, ime_r, drp_r, mef_r, etc_r, bce_r} <= 10'h000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PHY strap: synchronised, caught once after reset release

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
			cap_cnt_r <= 2'h0;
			phy_ext_r <= 1'b0;
		end else begin
			strap_s1_r <= PHY_CHOICE_STRAP;
			strap_s2_r <= strap_s1_r;
			if (cap_cnt_r != 2'h3) begin
				cap_cnt_r <= cap_cnt_r + 2'h1;
			end
			if (cap_cnt_r == 2'h2) begin
				phy_ext_r <= strap_s2_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Soft reset sequencer

	assign lite_busy = (st_r == HWC_ST_LITE);
	assign full_busy = (st_r == HWC_ST_FULL) || (st_r == HWC_ST_LOAD);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r <= HWC_ST_IDLE;
			seq_cnt_r <= 8'h00;
		end else begin
			case (st_r)
			HWC_ST_IDLE: begin
				seq_cnt_r <= 8'h00;
				// Full reset wins when both bits are written together
				if (wr_en && PWDATA[`HWC_B_FULL_SOFT_RESET]) begin
					st_r <= HWC_ST_FULL;
				end else if (wr_en && PWDATA[`HWC_B_LITE_SOFT_RESET]) begin
					st_r <= HWC_ST_LITE;
				end
			end
			HWC_ST_LITE: begin
				seq_cnt_r <= seq_cnt_r + 8'h01;
				if (seq_cnt_r == 8'(`HWC_LITE_RST_CYC - 1)) begin
					st_r <= HWC_ST_IDLE;
				end
			end
			HWC_ST_FULL: begin
				seq_cnt_r <= seq_cnt_r + 8'h01;
				if (seq_cnt_r == 8'(`HWC_FULL_RST_CYC - 1)) begin
					st_r <= HWC_ST_LOAD;
				end
			end
			HWC_ST_LOAD: begin
				if (EE_LOAD_DONE) begin
					st_r <= HWC_ST_IDLE;
				end
			end
			default: begin
				st_r <= HWC_ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			LITE_RESET <= 1'b0;
			FULL_RESET <= 1'b0;
			EXT_PHY_RESET <= 1'b0;
			USB_PHY_DISCONNECT <= 1'b0;
			EE_RELOAD_REQ <= 1'b0;
		end else begin
			// Lite reset touches neither USB core, EEPROM nor USB PHY
			LITE_RESET <= lite_busy;
			FULL_RESET <= (st_r == HWC_ST_FULL);
			EXT_PHY_RESET <= (st_r == HWC_ST_FULL) & phy_ext_r;
			USB_PHY_DISCONNECT <= full_busy;
			EE_RELOAD_REQ <= (st_r == HWC_ST_FULL) &&
				seq_cnt_r == 8'(`HWC_FULL_RST_CYC - 1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Datapath steering

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			DESC_SRC_RAM <= 1'b0;
			MII_PIN_OE <= 1'b0;
			GPIO_MII_OVERRIDE <= 1'b0;
			RX_BYTE_OFFSET <= 2'h0;
			ERR_FRAME_DISCARD <= 1'b0;
			MULTI_FRAME_PACK <= 1'b0;
			BURST_LIMIT_EN <= 1'b0;
		end else begin
			DESC_SRC_RAM <= ~EE_PRESENT & eem_r;
			MII_PIN_OE <= ime_r & ~phy_ext_r;
			GPIO_MII_OVERRIDE <= ime_r & ~phy_ext_r;
			RX_BYTE_OFFSET <= rxoff_r;
			ERR_FRAME_DISCARD <= drp_r;
			MULTI_FRAME_PACK <= mef_r;
			BURST_LIMIT_EN <= bce_r;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			BULK_IN_NAK <= 1'b0;
			BULK_IN_ZLP <= 1'b0;
			BULK_OUT_STALL <= 1'b0;
		end else begin
			BULK_IN_NAK <= BULK_IN_TOKEN & RX_FIFO_EMPTY & bir_r;
			BULK_IN_ZLP <= BULK_IN_TOKEN & RX_FIFO_EMPTY & ~bir_r;
			// Stall holds until a soft reset clears the pipe
			if (TX_LOSS_OF_SYNC & ~sbp_r) begin
				BULK_OUT_STALL <= 1'b1;
			end else if (soft_clr) begin
				BULK_OUT_STALL <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Activity LED: one on period then one off period per burst

	logic [22:0] led_cnt_r;
	logic led_busy_r;
	logic [22:0] led_last;

	assign led_last = activity_led_fast_bypass_r ? 23'(`HWC_LED_FAST_CYC - 1) : 23'(LED_NORMAL_CYC - 1);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			led_cnt_r <= 23'h000000;
			led_busy_r <= 1'b0;
			ACT_LED <= 1'b0;
		end else if (!led_busy_r) begin
			led_cnt_r <= 23'h000000;
			if (ACT_EVENT) begin
				led_busy_r <= 1'b1;
				ACT_LED <= 1'b1;
			end
		end else if (led_cnt_r >= led_last) begin
			led_cnt_r <= 23'h000000;
			ACT_LED <= 1'b0;
			led_busy_r <= ACT_LED;
		end else begin
			led_cnt_r <= led_cnt_r + 23'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// EEPROM wait timer; limit chosen by the timeout select bit

	logic [21:0] ee_cnt_r;
	logic [21:0] ee_last;

	assign ee_last = etc_r ? 22'(`HWC_EE_SHORT_CYC - 1) : 22'(EE_LONG_CYC - 1);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ee_cnt_r <= 22'h000000;
			EE_TIMEOUT <= 1'b0;
		end else begin
			// Compare with >= so a switch to the short limit cannot overrun the count
			EE_TIMEOUT <= EE_WAIT && ee_cnt_r >= ee_last;
			if (!EE_WAIT || ee_cnt_r >= ee_last) begin
				ee_cnt_r <= 22'h000000;
			end else begin
				ee_cnt_r <= ee_cnt_r + 22'h000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	logic [7:0] ast_ee_gap_r;

	// Short-limit waiting cycles since the last timeout pulse
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ast_ee_gap_r <= 8'h00;
		end else if (!EE_WAIT || !etc_r || EE_TIMEOUT) begin
			ast_ee_gap_r <= 8'h00;
		end else if (ast_ee_gap_r != 8'hff) begin
			ast_ee_gap_r <= ast_ee_gap_r + 8'h01;
		end
	end

	sequence s_lite_start;
		st_r == HWC_ST_IDLE && wr_en && PWDATA[`HWC_B_LITE_SOFT_RESET] && !PWDATA[`HWC_B_FULL_SOFT_RESET];
	endsequence

	sequence s_full_start;
		st_r == HWC_ST_IDLE && wr_en && PWDATA[`HWC_B_FULL_SOFT_RESET];
	endsequence

	AST_DESC_SRC: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(!EE_PRESENT && eem_r) |=> DESC_SRC_RAM)
		else $error("descriptor RAM not selected");
	AST_EE_IGNORE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		EE_PRESENT |=> !DESC_SRC_RAM)
		else $error("emulation bit acted with EEPROM present");
	AST_PROTECT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(soft_clr && protect_r && !wr_en) |=> protect_r && $stable(eem_r))
		else $error("protected field lost on soft reset");
	AST_NAK: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(BULK_IN_TOKEN && RX_FIFO_EMPTY) |=> (BULK_IN_NAK != BULK_IN_ZLP) && BULK_IN_NAK == $past(bir_r))
		else $error("wrong empty bulk-in answer");
	AST_STALL: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(TX_LOSS_OF_SYNC && !sbp_r) |=> BULK_OUT_STALL)
		else $error("bulk-out not stalled");
	AST_MII_EXT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		phy_ext_r |=> !MII_PIN_OE && !GPIO_MII_OVERRIDE)
		else $error("MII pins driven with external PHY");
	AST_EE_SHORT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		ast_ee_gap_r <= 8'h80)
		else $error("short EEPROM timeout missed");
	AST_LITE_DONE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		s_lite_start |=> ##1 LITE_RESET ##[1:AST_LITE_MAX] (st_r == HWC_ST_IDLE && !rd_word[`HWC_B_LITE_SOFT_RESET]))
		else $error("lite reset bit did not clear");
	AST_DISCONNECT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		s_full_start |=> ##1 USB_PHY_DISCONNECT [*8] ##[1:AST_FULL_MAX] EE_RELOAD_REQ)
		else $error("USB PHY not held disconnected or no reload");
	AST_RSVD: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		PREADY && !PWRITE |-> PRDATA[31:17] == 15'h0000 && PRDATA[14:13] == 2'h0)
		else $error("reserved bits read nonzero");
endmodule

// ### design/hwc_params.svh
// Offsets, field positions, reset values and timing counts of the
// hardware configuration register block.
// Assumes a 100 MHz core clock; included by hwc_top and tb_top.
`ifndef HWC_PARAMS_SVH
`define HWC_PARAMS_SVH

`define HWC_CLK_MHZ 100
`define HWC_HW_CONFIG_OFS 12'h014
`define HWC_ADDR_W 12
`define HWC_RESET_VAL 32'h0000_0000

`define HWC_B_EEM 16
`define HWC_B_PROTECT 15
`define HWC_B_BIR 12
`define HWC_B_ACTIVITY_LED_FAST_BYPASS 11
`define HWC_B_RXOFF_HI 10
`define HWC_B_RXOFF_LO 9
`define HWC_B_SBP 8
`define HWC_B_IME 7
`define HWC_B_DRP 6
`define HWC_B_MEF 5
`define HWC_B_ETC 4
`define HWC_B_LITE_SOFT_RESET 3
`define HWC_B_PSEL 2
`define HWC_B_BCE 1
`define HWC_B_FULL_SOFT_RESET 0

// Times in their own units
`define HWC_LED_NORMAL_MS 80
`define HWC_LED_FAST_US 15
`define HWC_EE_LONG_MS 30
`define HWC_EE_SHORT_NS 1280

// Derived cycle counts (below 4096 cycles)
`define HWC_LED_FAST_CYC (`HWC_LED_FAST_US * `HWC_CLK_MHZ)
`define HWC_EE_SHORT_CYC (`HWC_EE_SHORT_NS * `HWC_CLK_MHZ / 1000)
`define HWC_LITE_RST_CYC 16
`define HWC_FULL_RST_CYC 32

`endif

// ### design/hwc_pkg.sv
// Types shared by the hardware configuration register block.
// Assumes nothing beyond the params header.
package hwc_pkg;
	typedef enum logic [3:0] {
		HWC_ST_IDLE = 4'b0001,
		HWC_ST_LITE = 4'b0010,
		HWC_ST_FULL = 4'b0100,
		HWC_ST_LOAD = 4'b1000
	} hwc_state_t;
	typedef logic [31:0] hwc_word_t;
endpackage

// ### sim/tb_top.sv
// Self-checking bench for the hardware configuration register block.
// Assumes hwc_top with shortened LED and EEPROM counts; drives APB directly.
`timescale 1ns/1ps
`include "hwc_params.svh"

module tb_top;
	import hwc_pkg::*;
	localparam logic [31:0] RW_MASK = 32'h0001_9ff2;
	localparam logic [11:0] CFG_ADDR = 12'h014;
	typedef struct packed {logic wr; hwc_word_t data; logic err;} hwc_exp_t;
	logic SYS_CLK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	hwc_word_t PWDATA = 32'h0;
	logic PHY_CHOICE_STRAP = 1'b1, EE_PRESENT = 1'b0, EE_WAIT = 1'b0, EE_LOAD_DONE = 1'b0;
	logic RX_FIFO_EMPTY = 1'b0, BULK_IN_TOKEN = 1'b0, TX_LOSS_OF_SYNC = 1'b0, ACT_EVENT = 1'b0;
	logic [31:0] PRDATA;
	logic [1:0] RX_BYTE_OFFSET;
	logic PREADY, PSLVERR, DESC_SRC_RAM, BULK_IN_NAK, BULK_IN_ZLP, BULK_OUT_STALL, MII_PIN_OE;
	logic GPIO_MII_OVERRIDE, ERR_FRAME_DISCARD, MULTI_FRAME_PACK, BURST_LIMIT_EN, ACT_LED;
	logic EE_TIMEOUT, LITE_RESET, FULL_RESET, EXT_PHY_RESET, USB_PHY_DISCONNECT, EE_RELOAD_REQ;
	int fails = 0, n_compared = 0, n;
	logic [31:0] lfsr = 32'h2947, v;
	hwc_exp_t exp_q[$], e;

	hwc_top #(.LED_NORMAL_CYC(200), .EE_LONG_CYC(300)) hwc_top_i (.SYS_CLK(SYS_CLK),
		.RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.PHY_CHOICE_STRAP(PHY_CHOICE_STRAP), .EE_PRESENT(EE_PRESENT), .EE_WAIT(EE_WAIT),
		.EE_LOAD_DONE(EE_LOAD_DONE), .RX_FIFO_EMPTY(RX_FIFO_EMPTY),
		.BULK_IN_TOKEN(BULK_IN_TOKEN), .TX_LOSS_OF_SYNC(TX_LOSS_OF_SYNC),
		.ACT_EVENT(ACT_EVENT), .DESC_SRC_RAM(DESC_SRC_RAM), .BULK_IN_NAK(BULK_IN_NAK),
		.BULK_IN_ZLP(BULK_IN_ZLP), .BULK_OUT_STALL(BULK_OUT_STALL),
		.MII_PIN_OE(MII_PIN_OE), .GPIO_MII_OVERRIDE(GPIO_MII_OVERRIDE),
		.RX_BYTE_OFFSET(RX_BYTE_OFFSET), .ERR_FRAME_DISCARD(ERR_FRAME_DISCARD),
		.MULTI_FRAME_PACK(MULTI_FRAME_PACK), .BURST_LIMIT_EN(BURST_LIMIT_EN),
		.ACT_LED(ACT_LED), .EE_TIMEOUT(EE_TIMEOUT), .LITE_RESET(LITE_RESET),
		.FULL_RESET(FULL_RESET), .EXT_PHY_RESET(EXT_PHY_RESET),
		.USB_PHY_DISCONNECT(USB_PHY_DISCONNECT), .EE_RELOAD_REQ(EE_RELOAD_REQ));

	always #5 SYS_CLK = ~SYS_CLK;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic pick(input int k);
		case (k)
			0: return ACT_LED;
			1: return EE_TIMEOUT;
			2: return EE_RELOAD_REQ;
			3: return USB_PHY_DISCONNECT;
			default: return LITE_RESET;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge SYS_CLK);
	endtask

	// Bounded wait; sees values as they stood at the edge
	task automatic wait_sig(input int k, input logic lvl, input int lim, output int c);
		c = 0;
		while (pick(k) !== lvl && c < lim) begin
			@(posedge SYS_CLK);
			c++;
		end
		if (c >= lim) begin
			fails++;
			$display("ERROR %0t: wait timed out", $time);
		end
	endtask

	// Called right after an edge; the note is judged by the monitor
	task automatic apb(input logic wr, input logic [11:0] a, input hwc_word_t d,
			input hwc_word_t exp, input logic err);
		int c;
		c = 0;
		exp_q.push_back('{wr, exp, err});
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge SYS_CLK);
			c++;
		end while (PREADY !== 1'b1 && c < 20);
		if (c >= 20) begin
			fails++;
			$display("ERROR %0t: no ready from slave", $time);
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask

	task automatic por();
		RSTN <= 1'b0;
		tick(10);
		RSTN <= 1'b1;
		tick(4);
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge SYS_CLK) begin
		if (PSEL && PENABLE && PREADY === 1'b1) begin
			e = exp_q.pop_front();
			if (!e.wr) chk(PRDATA, e.data);
			chk({31'h0, PSLVERR}, {31'h0, e.err});
		end
	end

	initial begin
		#500000;
		fails++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		por();
		apb(1'b0, CFG_ADDR, 32'h0, 32'h4, 1'b0);
		apb(1'b1, 12'h018, 32'hffff_ffff, 32'h0, 1'b1);
		apb(1'b1, CFG_ADDR, 32'hffff_fff6, 32'h0, 1'b0);
		apb(1'b0, CFG_ADDR, 32'h0, 32'h0001_9ff6, 1'b0);
		chk({31'h0, MII_PIN_OE | GPIO_MII_OVERRIDE}, 32'h0);
		// Full reset with protection kept by the same write
		apb(1'b1, CFG_ADDR, 32'h0001_8001, 32'h0, 1'b0);
		#1 chk({29'h0, FULL_RESET, EXT_PHY_RESET, USB_PHY_DISCONNECT}, 32'h7);
		@(posedge SYS_CLK);
		wait_sig(2, 1'b1, 60, n);
		EE_LOAD_DONE <= 1'b1;
		@(posedge SYS_CLK);
		EE_LOAD_DONE <= 1'b0;
		wait_sig(3, 1'b0, 10, n);
		apb(1'b0, CFG_ADDR, 32'h0, 32'h0001_8004, 1'b0);
		// Internal PHY from here on
		PHY_CHOICE_STRAP <= 1'b0;
		por();
		apb(1'b0, CFG_ADDR, 32'h0, 32'h0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			v = lfsr & ~32'h9;
			EE_PRESENT <= lfsr[20];
			// RX path is never enabled here, so offset writes stay legal
			apb(1'b1, CFG_ADDR, v, 32'h0, 1'b0);
			apb(1'b0, CFG_ADDR, 32'h0, v & RW_MASK, 1'b0);
			chk({31'h0, DESC_SRC_RAM}, {31'h0, v[16] & ~lfsr[20]});
			chk({31'h0, MII_PIN_OE & GPIO_MII_OVERRIDE}, {31'h0, v[7]});
			chk({30'h0, RX_BYTE_OFFSET}, {30'h0, v[10:9]});
			chk({29'h0, ERR_FRAME_DISCARD, MULTI_FRAME_PACK, BURST_LIMIT_EN},
				{29'h0, v[6], v[5], v[1]});
		end
		RX_FIFO_EMPTY <= 1'b1;
		for (int b = 0; b < 2; b++) begin
			apb(1'b1, CFG_ADDR, b << 12, 32'h0, 1'b0);
			BULK_IN_TOKEN <= 1'b1;
			@(posedge SYS_CLK);
			BULK_IN_TOKEN <= 1'b0;
			#1 chk({30'h0, BULK_IN_NAK, BULK_IN_ZLP}, b ? 32'h2 : 32'h1);
			@(posedge SYS_CLK);
		end
		for (int b = 1; b >= 0; b--) begin
			apb(1'b1, CFG_ADDR, b << 8, 32'h0, 1'b0);
			TX_LOSS_OF_SYNC <= 1'b1;
			@(posedge SYS_CLK);
			TX_LOSS_OF_SYNC <= 1'b0;
			tick(2);
			chk({31'h0, BULK_OUT_STALL}, {31'h0, ~b[0]});
		end
		// Lite reset keeps protected fields and drops the sticky stall
		apb(1'b1, CFG_ADDR, 32'h0001_9ff8, 32'h0, 1'b0);
		tick(2);
		chk({29'h0, LITE_RESET, FULL_RESET, USB_PHY_DISCONNECT}, 32'h4);
		apb(1'b0, CFG_ADDR, 32'h0, 32'h0001_8008, 1'b0);
		wait_sig(4, 1'b0, 40, n);
		apb(1'b0, CFG_ADDR, 32'h0, 32'h0001_8000, 1'b0);
		chk({31'h0, BULK_OUT_STALL}, 32'h0);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, CFG_ADDR, s << 4, 32'h0, 1'b0);
			EE_WAIT <= 1'b1;
			wait_sig(1, 1'b1, 2000, n);
			chk(n >= (s ? 128 : 300) && n <= (s ? 131 : 303), 32'h1);
			EE_WAIT <= 1'b0;
			apb(1'b1, CFG_ADDR, s << 11, 32'h0, 1'b0);
			ACT_EVENT <= 1'b1;
			@(posedge SYS_CLK);
			ACT_EVENT <= 1'b0;
			wait_sig(0, 1'b1, 5, n);
			wait_sig(0, 1'b0, 4000, n);
			chk(n >= (s ? 1500 : 200) && n <= (s ? 1502 : 202), 32'h1);
			tick(s ? 1510 : 210);
		end
		end_sim();
	end
endmodule
